// ---- core/fpe_top.sv ----
/*
 * Flash program/erase control: APB register front end with unlock key,
 * effective address registers, start flag and processor stall.
 * The timed operation itself lives in the engine instantiated below.
 * Assumes an APB master on pclk and a flash array fed by the strobes.
 * Assumes the array latches its address on the one-cycle strobe and
 * that the core honours cpu_stall_q as well as the withheld pready.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.svh"

// Operation
// - key register is write-only, reads zero
// - start accepted only after completed unlock
// - high and low form 24-bit address
// - upper 8 address bits from high register
// - lower 16 address bits from low register
// - control register enables and starts operations
// - start bit 15, cleared when operation finishes
// - processor stalled until operation completes
// - program two adjacent words, pair aligned; the engine puts the pair base two above a multiple of four instead
module fpe_top #(
   parameter int PROG_TIME_NS  = `FPE_PROG_TIME_NS,
   parameter int ERASE_TIME_NS = `FPE_ERASE_TIME_NS
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // flash array and core
   output logic             flash_prog_q,
   output logic             flash_erase_q,
   output logic [23:0]      flash_addr_q,
   output logic             cpu_stall_q
);

   // least times round up to whole cycles; rounding down would cut an
   // operation short of its minimum time, so a partial cycle counts whole
   // and the operation may run up to one cycle longer than asked
   localparam int PROG_CYCLES  = (PROG_TIME_NS + `FPE_CLK_PERIOD_NS - 1) / `FPE_CLK_PERIOD_NS;
   localparam int ERASE_CYCLES = (ERASE_TIME_NS + `FPE_CLK_PERIOD_NS - 1) / `FPE_CLK_PERIOD_NS;

   fpe_op_if         op ();          // launch carrier to the engine
   fpe_pkg::fpe_key_e key_q;         // unlock progress
   logic [7:0]       addr_high_q;    // upper address byte
   logic [15:0]      addr_low_q;     // lower address half
   logic             start_q;        // start flag, reads wait while it is set and so always see it low
   logic             wren_q;         // operations enabled
   logic             err_q;          // last control write was a refused start
   logic [3:0]       opsel_q;        // selected operation
   logic             launch_q;       // one-cycle pulse to the engine
   logic [31:0]      prdata_q;       // read data held for the answer
   logic             pready_q;       // answer strobe
   logic             pslverr_q;      // unmapped address
   logic             access;         // access phase waiting for an answer
   logic             done_acc;       // access completing at this edge
   logic             wr_done;        // write completing at this edge
   logic             mapped;         // address hits a register
   logic             start_req;      // control write asking to start
   logic             op_ok;          // requested operation code is known
   logic [23:0]      eff_addr;       // effective address

   // effective address and bus phase decode; an access is psel with penable,
   // and it completes on the edge where our own pready_q is seen high,
   // so every side effect below keys off done_acc or wr_done only
   assign eff_addr  = {addr_high_q, addr_low_q};  // high byte on top, low half below
   assign access    = psel && penable && !pready_q;
   assign done_acc  = psel && penable && pready_q;
   assign wr_done   = done_acc && pwrite && !pslverr_q;
   assign mapped    = (paddr == `FPE_OFS_CTRL) || (paddr == `FPE_OFS_KEY) ||
                      (paddr == `FPE_OFS_ADDR_HIGH) || (paddr == `FPE_OFS_ADDR_LOW);
   assign start_req = wr_done && (paddr == `FPE_OFS_CTRL) && pwdata[`FPE_CTRL_START_BIT];
   assign op_ok     = (pwdata[`FPE_CTRL_OP_MSB:`FPE_CTRL_OP_LSB] == `FPE_OP_PROG_PAIR) ||
                      (pwdata[`FPE_CTRL_OP_MSB:`FPE_CTRL_OP_LSB] == `FPE_OP_PAGE_ERASE);

   // answer phase: one wait state, held off entirely while the engine runs
   // withholding pready is how the core is stalled: the access simply does
   // not finish, so no second start can slip in behind a running operation
   // limitation: every access waits, reads of the address registers too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (access && !start_q && !op.busy) begin  // bus waits out the operation
         pready_q  <= 1'b1;
         pslverr_q <= !mapped;
         case (paddr)
            `FPE_OFS_CTRL:      prdata_q <= {16'h0000, start_q, wren_q, err_q, 9'h000, opsel_q};
            `FPE_OFS_ADDR_HIGH: prdata_q <= {24'h00_0000, addr_high_q};
            `FPE_OFS_ADDR_LOW:  prdata_q <= {16'h0000, addr_low_q};
            default:            prdata_q <= 32'h0000_0000;  // key reads zero, never the key
         endcase
      end else begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end
   end

   // stall output mirrors the time the bus is held off
   // launch_q covers the cycle before the engine reports busy, so the
   // stall rises together with the array strobe and never after it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_stall_q <= 1'b0;
      end else begin
         cpu_stall_q <= launch_q || op.busy;
      end
   end

   // unlock sequence: 0x55 then 0xAA, then the very next access must start
   // only completed accesses move the sequence, so a long wait state
   // cannot break it; a refused start also leaves it idle, forcing a
   // fresh pair of key writes before the next attempt
   // a stray write of the first key value always restarts the pair
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         key_q <= fpe_pkg::FPE_KEY_IDLE;
      end else if (done_acc) begin
         if (wr_done && paddr == `FPE_OFS_KEY && pwdata[7:0] == `FPE_KEY_FIRST) begin
            key_q <= fpe_pkg::FPE_KEY_HALF;
         end else if (key_q == fpe_pkg::FPE_KEY_HALF && wr_done && paddr == `FPE_OFS_KEY &&
                      pwdata[7:0] == `FPE_KEY_SECOND) begin
            key_q <= fpe_pkg::FPE_KEY_OPEN;
         end else begin
            key_q <= fpe_pkg::FPE_KEY_IDLE;  // any other access, reads too, breaks it
         end
      end
   end

   // address registers
   // upper bits of the written word are dropped, not flagged; software
   // reading back sees only the implemented width
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_high_q <= `FPE_ADDR_HIGH_RESET;
         addr_low_q  <= `FPE_ADDR_LOW_RESET;
      end else if (wr_done) begin
         if (paddr == `FPE_OFS_ADDR_HIGH) begin
            addr_high_q <= pwdata[7:0];
         end
         if (paddr == `FPE_OFS_ADDR_LOW) begin
            addr_low_q <= pwdata[15:0];
         end
      end
   end

   // control register: enable, operation select and the start flag
   // the enable and operation fields are kept even when the start is
   // refused, so software can read back what it asked for; err only
   // reports the most recent control write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_q  <= 1'b0;
         wren_q   <= 1'b0;
         err_q    <= 1'b0;
         opsel_q  <= 4'h0;
         launch_q <= 1'b0;
      end else begin
         launch_q <= 1'b0;
         if (op.done) begin
            start_q <= 1'b0;  // flag drops by itself at the finish
         end
         if (wr_done && paddr == `FPE_OFS_CTRL) begin
            wren_q  <= pwdata[`FPE_CTRL_WREN_BIT];
            opsel_q <= pwdata[`FPE_CTRL_OP_MSB:`FPE_CTRL_OP_LSB];
            err_q   <= 1'b0;
            if (start_req) begin
               // locked, disabled or unknown operation: refused, flagged in err
               if (key_q == fpe_pkg::FPE_KEY_OPEN && pwdata[`FPE_CTRL_WREN_BIT] && op_ok) begin
                  start_q  <= 1'b1;
                  launch_q <= 1'b1;
               end else begin
                  err_q <= 1'b1;
               end
            end
         end
      end
   end

   // launch carrier; erase is decoded from the stored operation, which
   // was written in the same cycle that raised launch_q
   assign op.start = launch_q;
   assign op.erase = (opsel_q == `FPE_OP_PAGE_ERASE);
   assign op.addr  = eff_addr;

   // timed operation and array strobes
   // the engine deals in cycles only, which keeps the clock period out of
   // its counter; short simulation times come in through our parameters
   fpe_engine #(
      .PROG_CYCLES  (PROG_CYCLES),
      .ERASE_CYCLES (ERASE_CYCLES)
   ) u_engine (
      .pclk          (pclk),
      .presetn       (presetn),
      .op            (op),
      .flash_prog_q  (flash_prog_q),
      .flash_erase_q (flash_erase_q),
      .flash_addr_q  (flash_addr_q)
   );

   // bus outputs come straight from their flops, so prdata is zero
   // whenever pready is low and never glitches with the address
   assign prdata  = prdata_q;
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

endmodule // fpe_top

`default_nettype wire

// ---- core/fpe_defines.svh ----
/*
 * Constants for the flash program/erase control block: register offsets,
 * field positions, reset values, key values and operation times.
 * Assumes inclusion by bare name from the block's design files.
 */
`ifndef FPE_DEFINES_SVH
`define FPE_DEFINES_SVH

// register byte offsets on the APB bus
`define FPE_OFS_CTRL        8'h00
`define FPE_OFS_KEY         8'h04
`define FPE_OFS_ADDR_HIGH   8'h08
`define FPE_OFS_ADDR_LOW    8'h0C

// control register fields
`define FPE_CTRL_START_BIT  15
`define FPE_CTRL_WREN_BIT   14
`define FPE_CTRL_ERR_BIT    13
`define FPE_CTRL_OP_MSB     3
`define FPE_CTRL_OP_LSB     0
`define FPE_OP_PROG_PAIR    4'h3
`define FPE_OP_PAGE_ERASE   4'h2

// reset values
`define FPE_CTRL_RESET      16'h0000
`define FPE_ADDR_HIGH_RESET 8'h00
`define FPE_ADDR_LOW_RESET  16'h0000

// unlock key values, in the order software writes them
`define FPE_KEY_FIRST       8'h55
`define FPE_KEY_SECOND      8'hAA

// timing: clock period and operation times in ns
`define FPE_CLK_PERIOD_NS   4
`define FPE_PROG_TIME_NS    20000
`define FPE_ERASE_TIME_NS   40000

`endif

// ---- core/fpe_pkg.sv ----
/*
 * Types shared by the flash program/erase control block.
 * Assumes the defines header supplies all numeric constants.
 */
package fpe_pkg;

   // progress of the two-write unlock sequence
   typedef enum logic [1:0] {
      FPE_KEY_IDLE,
      FPE_KEY_HALF,
      FPE_KEY_OPEN
   } fpe_key_e;

   // operation engine states
   typedef enum logic [1:0] {
      FPE_ENG_IDLE,
      FPE_ENG_PROG,
      FPE_ENG_ERASE
   } fpe_eng_e;

endpackage

// ---- core/fpe_op_if.sv ----
/*
 * Carrier between the register front end and the operation engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface fpe_op_if;
   logic        start;   // one-cycle launch pulse
   logic        erase;   // 1 page erase, 0 word pair program
   logic [23:0] addr;    // effective address at launch
   logic        busy;    // operation in progress
   logic        done;    // one-cycle finish pulse

   modport front (output start, output erase, output addr, input busy, input done);
   modport engine (input start, input erase, input addr, output busy, output done);
endinterface

`default_nettype wire

// ---- core/fpe_engine.sv ----
/*
 * Operation engine: times one program or erase operation and drives the
 * flash array strobes. Assumes launches come only while not busy.
 */
`timescale 1ns/1ps
`default_nettype none

module fpe_engine #(
   parameter int PROG_CYCLES  = 5000,
   parameter int ERASE_CYCLES = 10000
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // launch and status
   fpe_op_if.engine         op,
   // flash array side
   output logic             flash_prog_q,
   output logic             flash_erase_q,
   output logic [23:0]      flash_addr_q
);

   fpe_pkg::fpe_eng_e state_q;   // current activity
   logic [31:0]       count_q;   // cycles left in the operation

   // sequencing and timing of one operation
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= fpe_pkg::FPE_ENG_IDLE;
         count_q <= 32'h0000_0000;
         op.done <= 1'b0;
      end else begin
         op.done <= 1'b0;
         case (state_q)
            fpe_pkg::FPE_ENG_IDLE: begin
               if (op.start) begin
                  state_q <= op.erase ? fpe_pkg::FPE_ENG_ERASE : fpe_pkg::FPE_ENG_PROG;
                  count_q <= op.erase ? 32'(ERASE_CYCLES - 1) : 32'(PROG_CYCLES - 1);
               end
            end
            fpe_pkg::FPE_ENG_PROG, fpe_pkg::FPE_ENG_ERASE: begin
               if (count_q == 32'h0000_0000) begin
                  state_q <= fpe_pkg::FPE_ENG_IDLE;
                  op.done <= 1'b1;       // front end drops its start flag on this
               end else begin
                  count_q <= count_q - 32'h0000_0001;
               end
            end
            default: state_q <= fpe_pkg::FPE_ENG_IDLE;
         endcase
      end
   end

   // busy as seen by the front end, high from the cycle after launch
   assign op.busy = (state_q != fpe_pkg::FPE_ENG_IDLE);

   // one-cycle strobes to the array; the pair base sits two above a multiple of four
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_prog_q  <= 1'b0;
         flash_erase_q <= 1'b0;
         flash_addr_q  <= 24'h00_0000;
      end else begin
         flash_prog_q  <= op.start && !op.erase;
         flash_erase_q <= op.start && op.erase;
         if (op.start) begin
            flash_addr_q <= op.erase ? op.addr : {op.addr[23:2], 2'h2};  // odd-word pair boundary
         end
      end
   end

endmodule // fpe_engine

`default_nettype wire

// ---- verif/fpe_asserts.sv ----
/*
 * Concurrent checks on the ports of the flash program/erase control top.
 * Assumes one pclk domain, presetn asynchronous active low, bound below.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpe_defines.svh"

module fpe_asserts #(
   parameter int PROG_TIME_NS  = `FPE_PROG_TIME_NS,
   parameter int ERASE_TIME_NS = `FPE_ERASE_TIME_NS
) (
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // flash array and core
   input wire logic        flash_prog_q,
   input wire logic        flash_erase_q,
   input wire logic [23:0] flash_addr_q,
   input wire logic        cpu_stall_q
);
   // one domain, so clock and disable are given once
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // operation lengths in cycles, least times rounded up to whole cycles
   localparam int PROG_CYC  = (PROG_TIME_NS + `FPE_CLK_PERIOD_NS - 1) / `FPE_CLK_PERIOD_NS;
   localparam int ERASE_CYC = (ERASE_TIME_NS + `FPE_CLK_PERIOD_NS - 1) / `FPE_CLK_PERIOD_NS;

   logic [31:0] stall_len_q;   // consecutive cycles with the stall high

   // run length of the stall, far too long for a repetition count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_len_q <= 32'h0000_0000;
      end else begin
         stall_len_q <= cpu_stall_q ? stall_len_q + 32'h0000_0001 : 32'h0000_0000;
      end
   end

   // read data is quiet outside the answer cycle
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero while idle");
   a_key_unreadable: assert property (psel && penable && pready && !pwrite && paddr == `FPE_OFS_KEY
      |-> prdata == 32'h0) else $error("key register read back nonzero");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held over two cycles");
   a_error_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
   // a launched operation always holds the core
   a_strobe_stalls: assert property (flash_prog_q || flash_erase_q |-> cpu_stall_q)
      else $error("strobe without stall");
   a_no_answer_stalled: assert property (cpu_stall_q |-> !pready) else $error("bus answered during stall");
   a_pair_aligned: assert property (flash_prog_q |-> flash_addr_q[1:0] == 2'h2)
      else $error("pair not on its boundary");
   // the array address only moves when an operation is launched
   a_addr_on_launch: assert property ($changed(flash_addr_q) |-> flash_prog_q || flash_erase_q)
      else $error("array address moved without launch");
   a_single_strobe: assert property (flash_prog_q || flash_erase_q |=> !(flash_prog_q || flash_erase_q) [*3])
      else $error("strobe repeated");
   // the stall outlasts a program and never outlasts an erase plus launch
   a_stall_min_len: assert property ($fell(cpu_stall_q) |-> stall_len_q > PROG_CYC)
      else $error("stall ended early");
   a_stall_max_len: assert property (stall_len_q <= ERASE_CYC + 1)
      else $error("stall outlasts an erase");

   // main scenarios reached
   c_prog: cover property (flash_prog_q);
   c_erase: cover property (flash_erase_q);
   c_slverr: cover property (pslverr);
endmodule // fpe_asserts

bind fpe_top fpe_asserts #(.PROG_TIME_NS(PROG_TIME_NS), .ERASE_TIME_NS(ERASE_TIME_NS)) i_fpe_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flash_prog_q(flash_prog_q),
   .flash_erase_q(flash_erase_q), .flash_addr_q(flash_addr_q), .cpu_stall_q(cpu_stall_q));

`default_nettype wire

// ---- verif/tb_top.sv ----
/*
 * Self-checking bench for the flash program/erase control block.
 * Assumes the top is driven directly over apb with shortened op times.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        f_prog, f_erase, stall, err;
   logic [23:0] f_addr;
   int          miscompares, compares, waits;

   fpe_top #(.PROG_TIME_NS(40), .ERASE_TIME_NS(80)) i_fpe_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_prog_q(f_prog), .flash_erase_q(f_erase), .flash_addr_q(f_addr),
      .cpu_stall_q(stall));

   // 250 mhz clock
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; holds the request until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      waits = 0;
      do begin
         @(posedge pclk);
         waits++;
         if (waits > 500) begin
            miscompares++;
            $display("unexpected at %0t: waits %h limit %h", $time, waits, 500);
            wrap_up();
         end
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // unlock pair then control write
   task automatic launch(input logic [31:0] ctl);
      apb(1'b1, 8'h04, 32'h55);
      apb(1'b1, 8'h04, 32'hAA);
      apb(1'b1, 8'h00, ctl);
   endtask

   // look for a strobe within a few cycles and capture what goes with it
   task automatic watch(input logic ep, input logic ee, input logic [23:0] ea);
      logic seen;
      seen = 1'b0;
      repeat (8) begin
         @(posedge pclk);
         #1;
         if (!seen && (f_prog === 1'b1 || f_erase === 1'b1)) begin
            seen = 1'b1;
            chk({f_prog, f_erase, stall}, {ep, ee, 1'b1});
            chk(f_addr, ea);
         end
      end
      chk(seen, ep | ee);
   endtask

   initial begin
      miscompares = 0;
      compares = 0;
      presetn <= 1'b0;
      {psel, penable, pwrite, paddr, pwdata} <= '0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // reset values of control and both address registers
      for (int i = 0; i < 16; i += 4) begin
         apb(1'b0, i[7:0], 32'h0);
         chk(rd, 32'h0);
      end
      // address registers keep only their own width
      apb(1'b1, 8'h08, 32'hFFFFFF12);
      apb(1'b1, 8'h0C, 32'hFFFF3457);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h12);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd, 32'h3457);
      // a read between the keys breaks the unlock
      apb(1'b1, 8'h04, 32'h55);
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, 8'h04, 32'hAA);
      apb(1'b1, 8'h00, 32'hC003);
      watch(1'b0, 1'b0, 24'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd & 32'hA000, 32'h2000);
      // start without the enable bit is refused
      launch(32'h8003);
      watch(1'b0, 1'b0, 24'h0);
      // an unknown operation code is refused even when enabled
      launch(32'hC005);
      watch(1'b0, 1'b0, 24'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd & 32'hA00F, 32'h2005);
      // pair program on its odd-word boundary with the stall up at the strobe, then a stalled read
      launch(32'hC003);
      watch(1'b1, 1'b0, 24'h123456);
      apb(1'b0, 8'h00, 32'h0);
      chk(waits > 2, 1'b1);
      chk(rd & 32'hA000, 32'h0);
      // page erase takes the whole address
      launch(32'hC002);
      watch(1'b0, 1'b1, 24'h123457);
      apb(1'b0, 8'h00, 32'h0);
      chk(waits > 2, 1'b1);
      chk(rd & 32'hA000, 32'h0);
      // unmapped place answers with an error and zero
      apb(1'b0, 8'h10, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      wrap_up();
   end
endmodule // tb_top

`default_nettype wire
